// File: core/sfr_read_seq.sv
// Purpose: read command decoder and data output sequencer of a serial flash
// Assumes: SCLK and CS_N come from the host; status bits come from this clock
// Notes:   array read port has one cycle latency; serial clock is oversampled
//
// Summary of operation
// - exit opcode returns to 24-bit addressing
// - 3-byte mode upper byte from extended register
// - basic read always takes 24-bit address
// - opcode and address sampled on rising edges
// - data changes on falling edges, MSB first
// - address increments per byte until deselect
// - basic reads ignored while busy
// - basic and 4-byte reads need standard mode
// - 4-byte basic read takes 32-bit address
// - fast read has eight dummy clocks
// - mode-dependent reads follow address mode width
// - 4-byte fast read: 32-bit, eight dummies
// - dual output: two bits per clock
// - 4-byte dual output: 32-bit address
// - quad output needs quad enable set
// - 4-byte quad output: 32-bit address
// - dual I/O: two-line address, four clocks
// - 4-byte dual I/O: 32-bit, standard mode
// - enter opcode selects 32-bit addressing
// - extended register supplies bits 31..24
module sfr_read_seq
   import sfr_pkg::*;
(
   input  wire logic                CLOCK,
   input  wire logic                RST_N,
   input  wire logic                SCLK,
   input  wire logic                CS_N,
   input  wire logic [3:0]          IO_IN,
   output      logic [3:0]          IO_OUT,
   output      logic [3:0]          IO_OE,
   input  wire logic                QUAD_ENABLE,
   input  wire logic                BUSY,
   input  wire logic                QPI_MODE,
   input  wire logic [7:0]          EXT_ADDR,
   output      logic [ARRAY_AW-1:0] MEM_ADDR,
   input  wire logic [7:0]          MEM_DATA,
   output      logic                WIDE_ADDRESS_MODE_FLAG
);

   ////////////////////////////////////////////////////////////////////////////
   // opcode decode

   // one opcode plus the current mode bits give the whole read recipe
   function automatic sfr_cfg_t decode(input logic [7:0] opc,
                                       input logic       wide,
                                       input logic       quad_enable,
                                       input logic       busy,
                                       input logic       qpi);
      sfr_cfg_t c;
      c = '{act: ACT_READ, use32: wide, dual_addr: 1'b0,
            dummy: DUMMY_FAST, lanes: LN_ONE};
      case (opc)
         OPC_READ: begin
            c.use32 = 1'b0;
            c.dummy = DUMMY_NONE;
            if (busy) begin
               c.act = ACT_IGNORE;
            end
         end
         OPC_READ4: begin
            c.use32 = 1'b1;
            c.dummy = DUMMY_NONE;
            if (busy) begin
               c.act = ACT_IGNORE;
            end
         end
         OPC_FAST: begin
            c.use32 = wide;
         end
         OPC_FAST4: begin
            c.use32 = 1'b1;
         end
         OPC_DUAL_OUT: begin
            c.lanes = LN_TWO;
         end
         OPC_DUAL_OUT4: begin
            c.lanes = LN_TWO;
            c.use32 = 1'b1;
         end
         OPC_QUAD_OUT, OPC_QUAD_OUT4: begin
            c.lanes = LN_FOUR;
            c.use32 = (opc == OPC_QUAD_OUT4) ? 1'b1 : wide;
            if (!quad_enable) begin
               c.act = ACT_IGNORE;
            end
         end
         OPC_DUAL_IO, OPC_DUAL_IO4: begin
            // mode-bit clocks stand in for the dummy clocks
            c.lanes     = LN_TWO;
            c.dual_addr = 1'b1;
            c.dummy     = DUMMY_NONE;
            c.use32     = (opc == OPC_DUAL_IO4) ? 1'b1 : wide;
         end
         OPC_EXIT_WIDE, OPC_ENTER_WIDE: begin
            c.act = ACT_MODESET;
         end
         default: begin
            c.act = ACT_IGNORE;
         end
      endcase
      // only the single-line opcode stream is decoded here
      if (qpi) begin
         c.act = ACT_IGNORE;
      end
      return c;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // state and edge detection

   sfr_regs_t           r;          // registered state
   sfr_regs_t           next_r;     // its next value
   logic                rise;       // serial clock rising edge seen
   logic                fall;       // serial clock falling edge seen
   logic                sel;        // chip selected, synchronised
   logic                addr_done;  // last address clock taken

   // edges come from the second and third stages only
   assign rise = r.sck_s2 & ~r.sck_q;
   assign fall = ~r.sck_s2 & r.sck_q;
   assign sel  = ~r.cs_s2;

   assign addr_done = sel && rise && (r.st == S_ADDR) &&
                      (r.cnt == (r.cfg.use32 ?
                                 (r.cfg.dual_addr ? ADDR32_2_LAST : ADDR32_LAST) :
                                 (r.cfg.dual_addr ? ADDR24_2_LAST : ADDR24_LAST)));

   ////////////////////////////////////////////////////////////////////////////
   // next-state logic

   always_comb begin
      logic [7:0]  opc;    // opcode with the newest bit
      logic [31:0] a;      // address with the newest bits
      logic [31:0] eff;    // effective array address
      sfr_cfg_t    c;      // decoded recipe
      logic [7:0]  byte_v; // byte being shifted out
      next_r = r;
      opc    = {r.cmd[6:0], r.io_s2[0]};
      a      = r.cfg.dual_addr ? {r.addr[29:0], r.io_s2[1], r.io_s2[0]}
                               : {r.addr[30:0], r.io_s2[0]};
      eff    = r.cfg.use32 ? a : {EXT_ADDR, a[23:0]};
      c      = decode(opc, r.wide, QUAD_ENABLE, BUSY, QPI_MODE);
      byte_v = (r.cnt == 6'h00) ? MEM_DATA : r.sh;

      // two-stage synchronisers on every pin input
      next_r.sck_s1 = SCLK;
      next_r.sck_s2 = r.sck_s1;
      next_r.sck_q  = r.sck_s2;
      next_r.cs_s1  = CS_N;
      next_r.cs_s2  = r.cs_s1;
      next_r.io_s1  = IO_IN;
      next_r.io_s2  = r.io_s1;

      if (!sel) begin
         // deselect ends any command; mode change only after exactly 8 bits
         if (r.st == S_MODESET) begin
            next_r.wide = (r.cmd == OPC_ENTER_WIDE);
         end
         next_r.st    = S_OPC;
         next_r.cnt   = 6'h00;
         next_r.io_oe = 4'h0;
      end else begin
         case (r.st)
            // opcode bits on rising edges
            S_OPC: begin
               if (rise) begin
                  next_r.cmd = opc;
                  next_r.cnt = 6'(r.cnt + 6'h01);
                  if (r.cnt == OPC_LAST) begin
                     next_r.cnt  = 6'h00;
                     next_r.cfg  = c;
                     next_r.addr = 32'h0000_0000;
                     case (c.act)
                        ACT_READ:    next_r.st = S_ADDR;
                        ACT_MODESET: next_r.st = S_MODESET;
                        default:     next_r.st = S_IGN;
                     endcase
                  end
               end
            end
            // address bits, one or two per rising edge
            S_ADDR: begin
               if (rise) begin
                  next_r.addr = a;
                  next_r.cnt  = 6'(r.cnt + 6'h01);
                  if (addr_done) begin
                     next_r.cnt      = 6'h00;
                     next_r.mem_addr = eff[ARRAY_AW-1:0];
                     if (r.cfg.dual_addr) begin
                        next_r.st = S_MODE;
                     end else if (r.cfg.dummy != DUMMY_NONE) begin
                        next_r.st = S_DUMMY;
                     end else begin
                        next_r.st = S_DATA;
                     end
                  end
               end
            end
            // continuation bits: value not used, host keeps them all ones
            S_MODE: begin
               if (rise) begin
                  next_r.cnt = 6'(r.cnt + 6'h01);
                  if (r.cnt == MODE_LAST) begin
                     next_r.cnt = 6'h00;
                     next_r.st  = S_DATA;
                  end
               end
            end
            // dummy clocks: input ignored, outputs left undriven
            S_DUMMY: begin
               if (rise) begin
                  next_r.cnt = 6'(r.cnt + 6'h01);
                  if (r.cnt == 6'({2'b00, r.cfg.dummy} - 6'h01)) begin
                     next_r.cnt = 6'h00;
                     next_r.st  = S_DATA;
                  end
               end
            end
            // data out on falling edges; drivers turn on at the first one
            S_DATA: begin
               if (fall) begin
                  case (r.cfg.lanes)
                     LN_TWO: begin
                        next_r.io_out = {2'b00, byte_v[7:6]};
                        next_r.io_oe  = 4'h3;
                        next_r.sh     = {byte_v[5:0], 2'b00};
                        next_r.cnt    = (r.cnt == 6'h00) ? 6'h03 : 6'(r.cnt - 6'h01);
                     end
                     LN_FOUR: begin
                        next_r.io_out = byte_v[7:4];
                        next_r.io_oe  = 4'hF;
                        next_r.sh     = {byte_v[3:0], 4'h0};
                        next_r.cnt    = (r.cnt == 6'h00) ? 6'h01 : 6'(r.cnt - 6'h01);
                     end
                     default: begin
                        next_r.io_out = {2'b00, byte_v[7], 1'b0};
                        next_r.io_oe  = 4'h2;
                        next_r.sh     = {byte_v[6:0], 1'b0};
                        next_r.cnt    = (r.cnt == 6'h00) ? 6'h07 : 6'(r.cnt - 6'h01);
                     end
                  endcase
                  // last slice of the byte: fetch the next one, wrapping
                  if (r.cnt == 6'h01) begin
                     next_r.mem_addr = r.mem_addr + ARRAY_AW'(1);
                  end
               end
            end
            // a clock after the mode opcode voids it
            S_MODESET: begin
               if (rise) begin
                  next_r.st = S_IGN;
               end
            end
            S_IGN: begin
               next_r.io_oe = 4'h0;
            end
            default: begin
               next_r.st = S_IGN;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // state register; deselected and 3-byte mode after reset

   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         r       <= '0;
         r.cs_s1 <= 1'b1;
         r.cs_s2 <= 1'b1;
         r.wide  <= WIDE_RESET;
      end else begin
         r <= next_r;
      end
   end

   // outputs straight from the state register
   assign IO_OUT                 = r.io_out;
   assign IO_OE                  = r.io_oe;
   assign MEM_ADDR               = r.mem_addr;
   assign WIDE_ADDRESS_MODE_FLAG = r.wide;

   ////////////////////////////////////////////////////////////////////////////
   // assertions

   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!RST_N);

   logic opc_end;  // eighth opcode bit taken this cycle
   assign opc_end = sel && rise && (r.st == S_OPC) && (r.cnt == OPC_LAST);

   sequence s_modeset_end;
      (r.st == S_MODESET) && sel ##1 !sel;
   endsequence

   sequence s_data_start;
      (r.st == S_DATA) && sel && fall && (r.cnt == 6'h00);
   endsequence

   a_deselect_idle: assert property (!sel |=> IO_OE == 4'h0)
      else $error("drivers on while deselected");
   a_enter_wide: assert property (s_modeset_end ##0 (r.cmd == OPC_ENTER_WIDE)
                                  |=> WIDE_ADDRESS_MODE_FLAG)
      else $error("enter opcode did not set 32-bit mode");
   a_exit_wide: assert property (s_modeset_end ##0 (r.cmd == OPC_EXIT_WIDE)
                                 |=> !WIDE_ADDRESS_MODE_FLAG)
      else $error("exit opcode did not clear 32-bit mode");
   a_busy_read: assert property (opc_end && BUSY && !QPI_MODE &&
                                 ({r.cmd[6:0], r.io_s2[0]} == OPC_READ)
                                 |=> r.st == S_IGN)
      else $error("basic read taken while busy");
   a_quad_gate: assert property (opc_end && !QUAD_ENABLE &&
                                 ({r.cmd[6:0], r.io_s2[0]} == OPC_QUAD_OUT)
                                 |=> (r.st == S_IGN) [*2])
      else $error("quad read taken without quad enable");
   a_qpi_block: assert property (opc_end && QPI_MODE |=> r.st == S_IGN)
      else $error("read decoded outside standard mode");
   a_rise_sample: assert property (sel && (r.st == S_OPC) && !rise
                                   |=> $stable(r.cnt))
      else $error("opcode bit taken without rising edge");
   a_fall_output: assert property (!(sel && fall) |=> $stable(IO_OUT))
      else $error("data changed off a falling edge");
   a_addr_step: assert property (sel && fall && (r.st == S_DATA) && (r.cnt == 6'h01)
                                 |=> MEM_ADDR == $past(MEM_ADDR) + ARRAY_AW'(1))
      else $error("read address did not advance");
   a_ext_upper: assert property (addr_done && !r.cfg.use32
                                 |=> MEM_ADDR[24] == $past(EXT_ADDR[0]))
      else $error("extended register not used for upper byte");
   a_dual_lanes: assert property (s_data_start ##0 (r.cfg.lanes == LN_TWO)
                                  |=> IO_OE == 4'h3)
      else $error("dual read not on two lines");
   a_dummy_quiet: assert property ((r.st == S_DUMMY) && sel |=> IO_OE == 4'h0)
      else $error("drivers on during dummy clocks");

endmodule

// File: dv/sfr_host.sv
// Purpose: host model that drives the flash serial bus in clock mode 0
// Assumes: 125 ns serial period; the serial clock stands still between frames
// Notes:   released lines toggle, so a stale level never passes for data
module sfr_host
   import sfr_pkg::*;
(
   output logic            sclk,
   output logic            cs_n,
   output logic [3:0]      io_in,
   input  wire logic [3:0] io_out,
   input  wire logic [3:0] io_oe
);
   timeunit 1ns;
   timeprecision 100ps;

   logic [3:0] host_out;   // host drive values
   logic [3:0] host_oe;    // lines the host drives
   logic [3:0] flt;        // level of lines nobody drives
   logic [7:0] got[$];     // bytes taken in the data phase
   logic [3:0] oe_or;      // union of device enables seen
   logic [3:0] oe_and;     // intersection of device enables seen

   ////////////////////////////////////////////////////////////////////////////
   // wire level from both parties
   always_comb
      for (int k = 0; k < 4; k++)
         io_in[k] = io_oe[k] ? io_out[k] : (host_oe[k] ? host_out[k] : flt[k]);

   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      host_out = 4'h0;
      host_oe = 4'h0;
      flt = 4'h5;
   end

   ////////////////////////////////////////////////////////////////////////////
   // one serial clock; release late in the high phase, well before the fall
   task automatic clk(input logic [3:0] o, oe, input bit rel, output logic [3:0] pin);
      host_out = o;
      host_oe = oe;
      #62.5;
      sclk = 1'b1;
      pin = io_in;
      flt = ~flt;
      if (rel) begin
         #40;
         host_oe = 4'h0;
         #22.5;
      end else begin
         #62.5;
      end
      sclk = 1'b0;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // whole frame: opcode, address, dummy or mode clocks, data
   task automatic frame(input logic [7:0] op, input logic [31:0] a, input int ab, dm, ln,
                        input bit du, input int nb);
      logic [3:0] p;
      logic [7:0] b;
      int         n;
      got.delete();
      oe_or = 4'h0;
      oe_and = 4'hF;
      b = 8'h00;
      #1.3;  // keeps serial edges off the system clock edges
      cs_n = 1'b0;
      for (int i = 7; i >= 0; i--)
         clk({3'h0, op[i]}, 4'h1, 1'b0, p);
      if (du)
         for (int i = ab - 1; i > 0; i -= 2)
            clk({2'h0, a[i], a[i-1]}, 4'h3, 1'b0, p);
      else
         for (int i = ab - 1; i >= 0; i--)
            clk({3'h0, a[i]}, 4'h1, dm == 0 && i == 0, p);
      // dual i/o: continuation bits all ones stand in for the dummies
      for (int i = 0; i < dm; i++)
         clk(du ? 4'h3 : {3'h0, i[0]}, du ? 4'h3 : 4'h1, i == dm - 1, p);
      n = nb * 8 / ln;
      for (int i = 0; i < n; i++) begin
         clk(4'h0, 4'h0, 1'b0, p);
         oe_or = oe_or | io_oe;
         oe_and = oe_and & io_oe;
         b = ln == 1 ? {b[6:0], p[1]} : ln == 2 ? {b[5:0], p[1:0]} : {b[3:0], p};
         if ((i + 1) % (8 / ln) == 0)
            got.push_back(b);
      end
      #100;
      cs_n = 1'b1;
      #400;
   endtask
endmodule

// File: dv/testbench.sv
// Purpose: self-checking bench of the read sequencer against a plain model
// Assumes: array contents are a fixed function of the byte address
// Notes:   every read opcode runs in both address modes and with QPI mode set; busy and quad refusals run their own opcodes
module testbench
   import sfr_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   logic                clock, rst_n, sclk, cs_n;
   logic [3:0]          io_in, io_out, io_oe;
   logic                quad_enable, busy, qpi_mode, wide_flag;
   logic [7:0]          ext_addr, mem_data;
   logic [ARRAY_AW-1:0] mem_addr;
   int                  bad_count, checked;
   integer              seed = 32'h71C5D831;
   int                  wide_m;  // model of the address mode
   logic [7:0]          ops[10] = '{OPC_READ, OPC_READ4, OPC_FAST, OPC_FAST4, OPC_DUAL_OUT,
      OPC_DUAL_OUT4, OPC_QUAD_OUT, OPC_QUAD_OUT4, OPC_DUAL_IO, OPC_DUAL_IO4};

   sfr_read_seq dut (.CLOCK(clock), .RST_N(rst_n), .SCLK(sclk), .CS_N(cs_n),
      .IO_IN(io_in), .IO_OUT(io_out), .IO_OE(io_oe), .QUAD_ENABLE(quad_enable),
      .BUSY(busy), .QPI_MODE(qpi_mode), .EXT_ADDR(ext_addr), .MEM_ADDR(mem_addr),
      .MEM_DATA(mem_data), .WIDE_ADDRESS_MODE_FLAG(wide_flag));
   sfr_host host (.sclk(sclk), .cs_n(cs_n), .io_in(io_in), .io_out(io_out), .io_oe(io_oe));

   ////////////////////////////////////////////////////////////////////////////
   // array model: contents depend on every address bit
   function automatic logic [7:0] mem_f(input logic [24:0] a);
      return a[7:0] ^ a[15:8] ^ a[23:16] ^ {a[24], 7'h35};
   endfunction

   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   always @(negedge clock) mem_data <= mem_f(mem_addr);

   task automatic check(input string name, input logic [31:0] seen, exp);
      checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] %s expected %0h seen %0h", name, exp, seen);
      end
   endtask

   task automatic stop_test();
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // one read frame, with the model's expected bytes and enables
   task automatic run(input logic [7:0] op, input logic q, b, p);
      int          ab, dm, ln, nb;
      bit          du, ok;
      logic [31:0] a;
      logic [24:0] ea;
      logic [3:0]  msk;
      logic [7:0]  e[$];
      @(negedge clock);
      quad_enable = q;
      busy = b;
      qpi_mode = p;
      ext_addr = $random(seed);
      a = $random(seed);
      if (op[0]) a[23:2] = '1;  // stream crosses a 16 Mbyte step or the array end
      ab = 32;
      dm = 8;
      ln = 1;
      du = 0;
      nb = 5;
      case (op)
         OPC_READ: begin
            ab = 24;
            dm = 0;
         end
         OPC_READ4: dm = 0;
         OPC_FAST: ab = wide_m ? 32 : 24;
         OPC_DUAL_OUT: begin
            ab = wide_m ? 32 : 24;
            ln = 2;
         end
         OPC_DUAL_OUT4: ln = 2;
         OPC_QUAD_OUT: begin
            ab = wide_m ? 32 : 24;
            ln = 4;
         end
         OPC_QUAD_OUT4: ln = 4;
         OPC_DUAL_IO: begin
            ab = wide_m ? 32 : 24;
            ln = 2;
            dm = 4;
            du = 1;
         end
         OPC_DUAL_IO4: begin
            ln = 2;
            dm = 4;
            du = 1;
         end
         default: ;  // fast read with fixed 32-bit address
      endcase
      ea = ab == 24 ? {ext_addr[0], a[23:0]} : a[24:0];
      ok = !p && !(b && (op == OPC_READ || op == OPC_READ4))
         && !(!q && (op == OPC_QUAD_OUT || op == OPC_QUAD_OUT4));
      msk = !ok ? 4'h0 : ln == 1 ? 4'h2 : ln == 2 ? 4'h3 : 4'hF;
      for (int i = 0; i < nb; i++)
         e.push_back(mem_f(ea + 25'(i)));
      host.frame(op, a, ab, dm, ln, du, nb);
      check("enables any", host.oe_or, msk);
      check("enables all", host.oe_and, msk);
      if (ok)
         for (int i = 0; i < nb; i++)
            check("read byte", host.got[i], e[i]);
   endtask

   task automatic mode(input logic [7:0] op, input int w);
      host.frame(op, 32'h0, 0, 0, 1, 0, 0);
      wide_m = w;
      for (int i = 0; i < 20 && wide_flag !== w[0]; i++)
         @(negedge clock);
      check("address mode", wide_flag, w);
      if (wide_flag !== w[0])
         stop_test();
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      rst_n = 1'b0;
      quad_enable = 1'b1;
      busy = 1'b0;
      qpi_mode = 1'b0;
      ext_addr = 8'h00;
      wide_m = 0;
      repeat (2) @(posedge clock);
      @(negedge clock) rst_n = 1'b1;
      check("reset mode", wide_flag, 0);
      repeat (5) @(negedge clock);
      foreach (ops[j]) run(ops[j], 1'b1, 1'b0, 1'b0);
      mode(OPC_ENTER_WIDE, 1);
      foreach (ops[j]) run(ops[j], 1'b1, 1'b0, 1'b0);
      mode(OPC_EXIT_WIDE, 0);
      run(OPC_FAST, 1'b1, 1'b0, 1'b0);
      run(OPC_READ, 1'b1, 1'b1, 1'b0);
      run(OPC_READ4, 1'b1, 1'b1, 1'b0);
      run(OPC_FAST, 1'b1, 1'b1, 1'b0);
      run(OPC_QUAD_OUT, 1'b0, 1'b0, 1'b0);
      run(OPC_QUAD_OUT4, 1'b0, 1'b0, 1'b0);
      mode(OPC_ENTER_WIDE, 1);
      @(negedge clock) rst_n = 1'b0;
      @(negedge clock) rst_n = 1'b1;
      wide_m = 0;
      check("reset mode", wide_flag, 0);
      // let the pin synchronisers settle before the next select
      repeat (3) @(negedge clock);
      foreach (ops[j]) run(ops[j], 1'b1, 1'b0, 1'b1);
      stop_test();
   end

   // hang guard
   initial begin
      // nearly three times the normal run, still under 100k system clocks
      #900000;
      check("run time", 1, 0);
      stop_test();
   end
endmodule

// File: inc/sfr_pkg.sv
// Purpose: shared constants and types of the serial flash read sequencer
// Assumes: one system clock; the flash bus is sampled, never used as a clock
// Notes:   every opcode, phase length and the address-mode reset value is named here once
package sfr_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // opcodes
   localparam logic [7:0] OPC_EXIT_WIDE  = 8'hE9;  // back to 24-bit addressing
   localparam logic [7:0] OPC_ENTER_WIDE = 8'hB7;  // 32-bit addressing
   localparam logic [7:0] OPC_READ       = 8'h03;  // basic read, always 24-bit
   localparam logic [7:0] OPC_READ4      = 8'h13;  // basic read, always 32-bit
   localparam logic [7:0] OPC_FAST       = 8'h0B;  // fast read, mode-dependent
   localparam logic [7:0] OPC_FAST4      = 8'h0C;  // fast read, always 32-bit
   localparam logic [7:0] OPC_DUAL_OUT   = 8'h3B;  // dual output
   localparam logic [7:0] OPC_DUAL_OUT4  = 8'h3C;
   localparam logic [7:0] OPC_QUAD_OUT   = 8'h6B;  // quad output
   localparam logic [7:0] OPC_QUAD_OUT4  = 8'h6C;
   localparam logic [7:0] OPC_DUAL_IO    = 8'hBB;  // dual address and data
   localparam logic [7:0] OPC_DUAL_IO4   = 8'hBC;

   ////////////////////////////////////////////////////////////////////////////
   // phase lengths, in serial clocks, stored as last count value; dummy lengths as the clock count itself
   localparam logic [5:0] OPC_LAST       = 6'h07;  // eight opcode bits
   localparam logic [5:0] ADDR24_LAST    = 6'h17;  // 24 single-line clocks
   localparam logic [5:0] ADDR32_LAST    = 6'h1F;  // 32 single-line clocks
   localparam logic [5:0] ADDR24_2_LAST  = 6'h0B;  // 12 two-line clocks
   localparam logic [5:0] ADDR32_2_LAST  = 6'h0F;  // 16 two-line clocks
   localparam logic [5:0] MODE_LAST      = 6'h03;  // four clocks of mode bits
   localparam logic [3:0] DUMMY_FAST     = 4'h8;   // eight dummy clocks
   localparam logic [3:0] DUMMY_NONE     = 4'h0;

   ////////////////////////////////////////////////////////////////////////////
   // array and reset values
   localparam int         ARRAY_AW       = 25;     // 256 Mbit = 32 Mbyte
   localparam logic       WIDE_RESET     = 1'b0;   // 3-byte mode after reset

   typedef enum logic [1:0] {LN_ONE, LN_TWO, LN_FOUR} sfr_lanes_t;
   typedef enum logic [1:0] {ACT_IGNORE, ACT_MODESET, ACT_READ} sfr_act_t;
   typedef enum logic [2:0] {
      S_OPC, S_ADDR, S_MODE, S_DUMMY, S_DATA, S_MODESET, S_IGN
   } sfr_state_t;

   // what an opcode asks of the later phases
   typedef struct packed {
      sfr_act_t   act;        // ignore, change mode or read
      logic       use32;      // 32-bit address
      logic       dual_addr;  // address on two lines, then mode bits
      logic [3:0] dummy;      // dummy clocks before data
      sfr_lanes_t lanes;      // data lines used for output
   } sfr_cfg_t;

   // all state of the sequencer
   typedef struct packed {
      logic                sck_s1, sck_s2, sck_q;
      logic                cs_s1, cs_s2;
      logic [3:0]          io_s1, io_s2;
      sfr_state_t          st;
      sfr_cfg_t            cfg;
      logic [7:0]          cmd;
      logic [5:0]          cnt;
      logic [31:0]         addr;
      logic [7:0]          sh;
      logic                wide;
      logic [ARRAY_AW-1:0] mem_addr;
      logic [3:0]          io_out;
      logic [3:0]          io_oe;
   } sfr_regs_t;

endpackage
